// ---- timer_irq_map.svh ----
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

// register byte addresses on the bus
`define ADDR_IRQ_ENABLE_ONE 12'h000
`define ADDR_EVENT_FLAGS_ONE 12'h004
`define ADDR_IRQ_ENABLE_TWO 12'h008
`define ADDR_EVENT_FLAGS_TWO 12'h00C
`define ADDR_ACCUM_RATE_CTRL 12'h010
`define ADDR_FREE_COUNTER 12'h014
`define ADDR_MODE_CTRL 12'h018

// field positions
`define FLG2_OVF_BIT 7
`define FLG2_PERIODIC_BIT 6
`define FLG2_ACC_OVF_BIT 5
`define FLG2_ACC_EDGE_BIT 4
`define FLG1_CH45_BIT 3
`define CTRL_CH45_SEL_BIT 2
`define CTRL_RATE_LSB 0
`define FLG1_CMP_LSB 4
`define FLG1_CAP_LSB 0
`define EN2_PRESCALE_LSB 0

// masks of implemented bits
`define EN2_WRITE_MASK 8'hF0
`define FLG2_IMPL_MASK 8'hF0
`define PRESCALE_MASK 8'h03

// reset values
`define EN_ONE_RST 8'h00
`define FLG_RST 8'h00
`define EN_TWO_RST 8'h00
`define CTRL_RST 8'h00
`define COUNT_RST 16'h0000
`define PRESCALE_RST 2'h0
`define BOOT_CNT_RST 7'h00
`define RDATA_RST 32'h0000_0000

// timing
`define PRESCALE_WINDOW 7'h40
`define COUNT_TOP 16'hFFFF
`define PRE_TOP_DIV1 4'h0
`define PRE_TOP_DIV4 4'h3
`define PRE_TOP_DIV8 4'h7
`define PRE_TOP_DIV16 4'hF
`define PERIODIC_BASE_LOG2 13
`define PERIODIC_DIV_W 16

`endif

// ---- timer_irq_pkg.sv ----
package timer_irq_pkg;

   typedef struct packed
   {
      logic [3:0] compare_match;
      logic [2:0] capture_edge;
      logic capture_four;
      logic compare_five;
      logic accum_overflow;
      logic accum_edge;
   } timer_events_s;

   typedef struct packed
   {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_s;

endpackage : timer_irq_pkg

// ---- timer_irq_flags_rti.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer_irq_map.svh"

module timer_irq_flags_rti
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   input wire timer_irq_pkg::timer_events_s i_events,
   input wire logic i_special_mode,
   output logic [15:0] o_free_running_counter,
   output logic o_counter_tick,
   output logic o_timer_irq
);

   // ==========================================================
   // bus decode
   // ==========================================================
   timer_irq_pkg::apb_req_s req;
   logic wr_en;
   logic [7:0] wbyte;

   assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
   assign wr_en = i_psel & i_penable & req.write & i_pstrb[0];
   assign wbyte = req.wdata[7:0];
   assign o_pready = 1'b1;

   function automatic logic wr_at(input logic [11:0] a);
      wr_at = wr_en && (req.addr == a);
   endfunction : wr_at

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `ADDR_IRQ_ENABLE_ONE) || (a == `ADDR_EVENT_FLAGS_ONE) ||
                   (a == `ADDR_IRQ_ENABLE_TWO) || (a == `ADDR_EVENT_FLAGS_TWO) ||
                   (a == `ADDR_ACCUM_RATE_CTRL) || (a == `ADDR_FREE_COUNTER) ||
                   (a == `ADDR_MODE_CTRL);
   endfunction : known_addr

   assign o_pslverr = i_psel & i_penable & ~known_addr(req.addr);

   // ==========================================================
   // control registers
   // ==========================================================
   logic [7:0] en_one_r;
   logic [7:0] en_two_r;
   logic [1:0] prescale_r;
   logic [7:0] ctrl_r;
   logic prescale_locked_r;
   logic [6:0] boot_cnt_r;
   logic ch45_sel;
   logic [1:0] rate_sel;

   assign ch45_sel = ctrl_r[`CTRL_CH45_SEL_BIT];
   assign rate_sel = ctrl_r[`CTRL_RATE_LSB +: 2];

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         en_one_r <= `EN_ONE_RST;
      else if (wr_at(`ADDR_IRQ_ENABLE_ONE))
         en_one_r <= wbyte;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         en_two_r <= `EN_TWO_RST;
      else if (wr_at(`ADDR_IRQ_ENABLE_TWO))
         en_two_r <= wbyte & `EN2_WRITE_MASK;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ctrl_r <= `CTRL_RST;
      else if (wr_at(`ADDR_ACCUM_RATE_CTRL))
         ctrl_r <= wbyte;
   end

   // one-shot prescaler window after reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         boot_cnt_r <= `BOOT_CNT_RST;
      else if (boot_cnt_r != `PRESCALE_WINDOW)
         boot_cnt_r <= boot_cnt_r + 7'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         prescale_r <= `PRESCALE_RST;
         prescale_locked_r <= 1'b0;
      end
      else if (wr_at(`ADDR_IRQ_ENABLE_TWO))
      begin
         if (i_special_mode)
            prescale_r <= wbyte[`EN2_PRESCALE_LSB +: 2];
         else if (!prescale_locked_r && boot_cnt_r < `PRESCALE_WINDOW)
         begin
            prescale_r <= wbyte[`EN2_PRESCALE_LSB +: 2];
            prescale_locked_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // free-running counter and prescaler
   // ==========================================================
   logic [3:0] pre_cnt_r;
   logic [15:0] count_r;
   logic tick;
   logic [3:0] pre_top;

   always_comb
   begin
      unique case (prescale_r)
         2'h0: pre_top = `PRE_TOP_DIV1;
         2'h1: pre_top = `PRE_TOP_DIV4;
         2'h2: pre_top = `PRE_TOP_DIV8;
         2'h3: pre_top = `PRE_TOP_DIV16;
      endcase
   end

   assign tick = (pre_cnt_r >= pre_top);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         pre_cnt_r <= 4'h0;
      else if (tick)
         pre_cnt_r <= 4'h0;
      else
         pre_cnt_r <= pre_cnt_r + 4'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         count_r <= `COUNT_RST;
      else if (tick)
         count_r <= count_r + 16'h0001;
   end

   logic overflow_evt;
   assign overflow_evt = tick && (count_r == `COUNT_TOP);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_free_running_counter <= `COUNT_RST;
         o_counter_tick <= 1'b0;
      end
      else
      begin
         o_free_running_counter <= count_r;
         o_counter_tick <= tick;
      end
   end

   // ==========================================================
   // periodic interrupt divider
   // ==========================================================
   // runs straight off the clock, so prescaler has no effect
   logic [`PERIODIC_DIV_W-1:0] rti_cnt_r;
   logic [`PERIODIC_DIV_W-1:0] rti_top;
   logic rti_evt;

   assign rti_top = `PERIODIC_DIV_W'((32'h1 << (`PERIODIC_BASE_LOG2 + 32'(rate_sel))) - 1);
   assign rti_evt = (rti_cnt_r >= rti_top);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rti_cnt_r <= '0;
      else if (rti_evt)
         rti_cnt_r <= '0;
      else
         rti_cnt_r <= rti_cnt_r + `PERIODIC_DIV_W'(1);
   end

   // ==========================================================
   // event flags
   // ==========================================================
   logic [7:0] flg_one_r;
   logic [7:0] flg_two_r;
   logic [7:0] set_one;
   logic [7:0] set_two;
   logic [7:0] clr_one;
   logic [7:0] clr_two;

   always_comb
   begin
      set_one = 8'h00;
      set_one[`FLG1_CMP_LSB +: 4] = {i_events.compare_match[0], i_events.compare_match[1],
                                     i_events.compare_match[2], i_events.compare_match[3]};
      set_one[`FLG1_CH45_BIT] = ch45_sel ? i_events.capture_four
                                         : i_events.compare_five;
      set_one[`FLG1_CAP_LSB +: 3] = {i_events.capture_edge[0], i_events.capture_edge[1],
                                     i_events.capture_edge[2]};
   end

   always_comb
   begin
      set_two = 8'h00;
      set_two[`FLG2_OVF_BIT] = overflow_evt;
      set_two[`FLG2_PERIODIC_BIT] = rti_evt;
      set_two[`FLG2_ACC_OVF_BIT] = i_events.accum_overflow;
      set_two[`FLG2_ACC_EDGE_BIT] = i_events.accum_edge;
   end

   // process, not assign: the strobe is read inside the function
   always_comb
   begin
      clr_one = wr_at(`ADDR_EVENT_FLAGS_ONE) ? wbyte : 8'h00;
      clr_two = wr_at(`ADDR_EVENT_FLAGS_TWO) ? (wbyte & `FLG2_IMPL_MASK) : 8'h00;
   end

   function automatic logic [7:0] flag_next(input logic [7:0] flg, input logic [7:0] clr,
                                            input logic [7:0] set);
      flag_next = (flg & ~clr) | set;
   endfunction : flag_next

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         flg_one_r <= `FLG_RST;
      else
         flg_one_r <= flag_next(flg_one_r, clr_one, set_one);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         flg_two_r <= `FLG_RST;
      else
         flg_two_r <= flag_next(flg_two_r, clr_two, set_two) & `FLG2_IMPL_MASK;
   end

   // ==========================================================
   // interrupt request
   // ==========================================================
   // bit 3 of enable one serves whichever ch4/5 function is selected
   logic [7:0] pend_one;
   logic [7:0] pend_two;

   assign pend_one = en_one_r & flg_one_r;
   assign pend_two = en_two_r & flg_two_r;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_timer_irq <= 1'b0;
      else
         o_timer_irq <= |{pend_one, pend_two};
   end

   // ==========================================================
   // read data
   // ==========================================================
   logic [7:0] rd_byte;

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (req.addr)
         `ADDR_IRQ_ENABLE_ONE: rd_byte = en_one_r;
         `ADDR_EVENT_FLAGS_ONE: rd_byte = flg_one_r;
         `ADDR_IRQ_ENABLE_TWO: rd_byte = en_two_r | {6'h00, prescale_r};
         `ADDR_EVENT_FLAGS_TWO: rd_byte = flg_two_r;
         `ADDR_ACCUM_RATE_CTRL: rd_byte = ctrl_r;
         `ADDR_MODE_CTRL: rd_byte = {7'h00, prescale_locked_r};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_prdata <= `RDATA_RST;
      else if (i_psel && !i_penable && !i_pwrite)
      begin
         if (i_paddr == `ADDR_FREE_COUNTER)
            o_prdata <= {16'h0000, count_r};
         else
            o_prdata <= {24'h000000, rd_byte};
      end
   end

endmodule : timer_irq_flags_rti
`default_nettype wire

// ---- timer_irq_flags_rti_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module timer_irq_checker
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [31:0] o_prdata,
   input wire timer_irq_pkg::timer_events_s i_events,
   input wire logic i_special_mode,
   input wire logic [15:0] o_free_running_counter,
   input wire logic o_counter_tick,
   input wire logic o_timer_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   logic far;
   assign far = (i_paddr[1:0] != 2'h0) || (i_paddr > 12'h018);
   // ==========
   // bus
   property p_ready; o_pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err; i_psel && i_penable |-> o_pslverr == far; endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_high; o_prdata[31:16] == 16'h0000; endproperty
   a_high: assert property (p_high) else $error("upper read bits set");
   property p_far; i_psel && !i_penable && !i_pwrite && far |=> o_prdata == 32'h0; endproperty
   a_far: assert property (p_far) else $error("unmapped read not zero");
   property p_hold; !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   // ==========
   // counter and request
   property p_tick; o_counter_tick |=>
      o_free_running_counter == $past(o_free_running_counter) + 16'h0001; endproperty
   a_tick: assert property (p_tick) else $error("tick without step");
   property p_still; !o_counter_tick |=> $stable(o_free_running_counter); endproperty
   a_still: assert property (p_still) else $error("counter moved");
   property p_fall; $fell(o_timer_irq) |-> $past(i_psel && i_penable && i_pwrite, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fell without write");
   property p_rst; $fell(i_rst) |-> !o_timer_irq && !o_counter_tick; endproperty
   a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule : timer_irq_checker
bind timer_irq_flags_rti timer_irq_checker i_timer_irq_checker (.i_clk(i_clk), .i_rst(i_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_prdata(o_prdata), .i_events(i_events), .i_special_mode(i_special_mode),
   .o_free_running_counter(o_free_running_counter), .o_counter_tick(o_counter_tick),
   .o_timer_irq(o_timer_irq));
`default_nettype wire

// ---- timer_irq_flags_rti_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer_irq_map.svh"
module timer_irq_flags_rti_test;
   logic i_clk = 0, i_rst = 1, psel = 0, pen = 0, pw = 0, smode = 0;
   logic pready, serr, pslverr, tick, irq;
   logic [11:0] pa = 0;
   logic [7:0] pd = 0, e1, e2;
   logic [31:0] rdata, prdata;
   logic [15:0] cnt;
   timer_irq_pkg::timer_events_s ev = '0;
   int err_total = 0, checks = 0, cyc = 0, n;
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) cyc <= i_rst ? 0 : cyc + 1;
   timer_irq_flags_rti i_timer_irq_flags_rti (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata({24'h000000, pd}),
      .i_pstrb(4'hF), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
      .i_events(ev), .i_special_mode(smode), .o_free_running_counter(cnt),
      .o_counter_tick(tick), .o_timer_irq(irq));
   // ==========
   // tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pw <= w;
      pa <= a;
      pd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("rdata", rdata, {24'h000000, e});
   endtask : rd
   task automatic tw;
      do @(posedge i_clk); while (tick !== 1'b1);
   endtask : tw
   task automatic wait_cyc(input int c);
      while (cyc < c) @(posedge i_clk);
   endtask : wait_cyc
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (100000) @(posedge i_clk);
      err_total++;
      complete_run();
   end
   // ==========
   // sequence
   initial
   begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 5; a++)
         rd(12'(a * 4), 8'h00);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h00);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h03);
      rd(`ADDR_IRQ_ENABLE_TWO, 8'h00);
      rd(`ADDR_MODE_CTRL, 8'h01);
      rd(12'h01C, 8'h00);
      chk("pslverr", serr, 1'b1);
      for (int p = 0; p < 2; p++)
      begin
         apb(1'b1, `ADDR_IRQ_ENABLE_ONE, p ? 8'h00 : 8'hFF);
         apb(1'b1, `ADDR_IRQ_ENABLE_TWO, p ? 8'h00 : 8'h30);
         apb(1'b1, `ADDR_ACCUM_RATE_CTRL, p ? 8'h00 : 8'h04);
         for (int j = 0; j < 11; j++)
         begin
            e1 = j > 6 ? 8'h80 >> (j - 7) : j > 3 ? 8'h04 >> (j - 4) : j == 3 - p ? 8'h08 : 8'h00;
            e2 = j == 1 ? 8'h20 : j == 0 ? 8'h10 : 8'h00;
            @(posedge i_clk);
            ev <= timer_irq_pkg::timer_events_s'(11'h001 << j);
            @(posedge i_clk);
            ev <= '0;
            repeat (2) @(posedge i_clk);
            chk("irq", irq, p == 0 && (e1 | e2) != 0);
            rd(`ADDR_EVENT_FLAGS_ONE, e1);
            rd(`ADDR_EVENT_FLAGS_TWO, e2);
            apb(1'b1, `ADDR_EVENT_FLAGS_ONE, ~e1);
            apb(1'b1, `ADDR_EVENT_FLAGS_TWO, ~e2);
            rd(`ADDR_EVENT_FLAGS_ONE, e1);
            rd(`ADDR_EVENT_FLAGS_TWO, e2);
            apb(1'b1, `ADDR_EVENT_FLAGS_ONE, e1);
            apb(1'b1, `ADDR_EVENT_FLAGS_TWO, e2);
            rd(`ADDR_EVENT_FLAGS_ONE, 8'h00);
         end
      end
      smode <= 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'(c));
         tw();
         tw();
         n = 0;
         do
         begin
            @(posedge i_clk);
            n++;
         end
         while (tick !== 1'b1);
         chk("divide", n, c ? 2 << c : 1);
      end
      // periodic timing with prescaler at sixteen
      wait_cyc(8185);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h00);
      wait_cyc(8200);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h40);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h43);
      repeat (2) @(posedge i_clk);
      chk("irq", irq, 1'b1);
      apb(1'b1, `ADDR_EVENT_FLAGS_TWO, 8'h40);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h00);
      chk("irq", irq, 1'b0);
      wait_cyc(16375);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h00);
      wait_cyc(16395);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h40);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h80);
      apb(1'b1, `ADDR_ACCUM_RATE_CTRL, 8'h01);
      apb(1'b1, `ADDR_EVENT_FLAGS_TWO, 8'h40);
      wait_cyc(32755);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h00);
      wait_cyc(32775);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'h40);
      while (cnt !== 16'hFFFF) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      rd(`ADDR_EVENT_FLAGS_TWO, 8'hC0);
      chk("irq", irq, 1'b1);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h00);
      repeat (2) @(posedge i_clk);
      chk("irq", irq, 1'b0);
      // second reset: prescaler write after the window is refused
      smode <= 1'b0;
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk("count", cnt, 16'h0000);
      chk("irq", irq, 1'b0);
      i_rst <= 1'b0;
      wait_cyc(70);
      apb(1'b1, `ADDR_IRQ_ENABLE_TWO, 8'h03);
      rd(`ADDR_IRQ_ENABLE_TWO, 8'h00);
      rd(`ADDR_MODE_CTRL, 8'h00);
      complete_run();
   end
endmodule : timer_irq_flags_rti_test
`default_nettype wire
